// ### rtl/rgbpwm_map.vh
// constants for the three-channel led dimming and pwm core
// What this block does
// - step count is absolute position difference
// - run lasts steps times step time
// - rise 15 then time 3 runs up
// - fall 1 then time 4 runs down
// - three independent reprogrammable pwm channels
// - five-bit duty, 32 settings
// - duty zero holds led off
// - mid duty gives proportional on ratio
// - duty max keeps led always on
// - duty accepted any time, even dimming
// - pwm never alters led_current_level
// - one thirty-first per step, 2.1 kHz clock
// - byte is 3-bit selector, 5-bit value
// - change starts at byte acknowledge
`ifndef RGBPWM_MAP_VH
`define RGBPWM_MAP_VH
// ---------------------------------------------------------------
// command selectors
// ---------------------------------------------------------------
`define RGBPWM_SEL_MSB       7
`define RGBPWM_SEL_LSB       5
`define RGBPWM_VAL_MSB       4
`define RGBPWM_SEL_SHUTDOWN  3'h0
`define RGBPWM_SEL_CURRENT   3'h1
`define RGBPWM_SEL_RED       3'h2
`define RGBPWM_SEL_GREEN     3'h3
`define RGBPWM_SEL_BLUE      3'h4
`define RGBPWM_SEL_RISE      3'h5
`define RGBPWM_SEL_FALL      3'h6
`define RGBPWM_SEL_RUN       3'h7
// ---------------------------------------------------------------
// reset values and limits
// ---------------------------------------------------------------
`define RGBPWM_RST_VAL       5'h00
`define RGBPWM_CODE_MAX      5'h1f
`define RGBPWM_PWM_LAST      5'h1e
// ---------------------------------------------------------------
// timing: clock 250 MHz, pwm period 2.1 kHz, time unit 8 ms
// ---------------------------------------------------------------
`define RGBPWM_CLK_HZ        250000000
`define RGBPWM_PWM_HZ        2100
`define RGBPWM_PWM_SLOTS     31
`define RGBPWM_STEP_UNIT_MS  8
`define RGBPWM_TICK_CYC      (`RGBPWM_CLK_HZ / (`RGBPWM_PWM_HZ * `RGBPWM_PWM_SLOTS))
`define RGBPWM_UNIT_CYC      (`RGBPWM_CLK_HZ / 1000 * `RGBPWM_STEP_UNIT_MS)
`endif

// ### rtl/rgbpwm_core.v
// three-channel led pwm and gradual dimming core behind a byte command port
`include "rgbpwm_map.vh"
module rgbpwm_core #(
  parameter TICK_CYC = `RGBPWM_TICK_CYC, // clocks per pwm slot
  parameter UNIT_CYC = `RGBPWM_UNIT_CYC  // clocks per 8 ms time unit
) (
  input  wire       clk,            // 250 MHz clock
  input  wire       rst_n,          // async active-low reset
  input  wire       cmd_valid,      // one-cycle pulse: byte acknowledged
  input  wire [7:0] cmd_byte,       // command byte
  output reg        led_red_on,     // red gate
  output reg        led_green_on,   // green gate
  output reg        led_blue_on,    // blue gate
  output reg  [4:0] led_current_level, // present step code
  output reg        shutdown_out,   // chip shut down
  output reg        dimming_busy    // dimming run in progress
);
  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  reg rst_s1_reg;
  reg rst_s2_reg;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  wire rst_l = rst_s2_reg;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // distance between two step codes; the direction is kept apart
  function [4:0] absdiff;
    input [4:0] a;
    input [4:0] b;
    begin
      absdiff = (a > b) ? (a - b) : (b - a);
    end
  endfunction

  // one code toward the end point; a bad end point cannot push past 0 or 31
  function [4:0] step_toward;
    input [4:0] code;
    input       up;
    begin
      if (up && code != `RGBPWM_CODE_MAX)
        step_toward = code + 5'h01;
      else if (!up && code != 5'h00)
        step_toward = code - 5'h01;
      else
        step_toward = code;
    end
  endfunction

  // one colour gate: on while the slot is below the duty code
  function gate_on;
    input [4:0] slot;
    input [4:0] duty;
    input       off;
    begin
      gate_on = !off && (slot < duty);
    end
  endfunction

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  wire [2:0] sel          = cmd_byte[`RGBPWM_SEL_MSB:`RGBPWM_SEL_LSB];
  wire [4:0] val          = cmd_byte[`RGBPWM_VAL_MSB:0];
  wire       cmd_shutdown = cmd_valid && (sel == `RGBPWM_SEL_SHUTDOWN);
  wire       cmd_current  = cmd_valid && (sel == `RGBPWM_SEL_CURRENT);
  wire       cmd_red      = cmd_valid && (sel == `RGBPWM_SEL_RED);
  wire       cmd_green    = cmd_valid && (sel == `RGBPWM_SEL_GREEN);
  wire       cmd_blue     = cmd_valid && (sel == `RGBPWM_SEL_BLUE);
  wire       cmd_rise     = cmd_valid && (sel == `RGBPWM_SEL_RISE);
  wire       cmd_fall     = cmd_valid && (sel == `RGBPWM_SEL_FALL);
  wire       cmd_run      = cmd_valid && (sel == `RGBPWM_SEL_RUN);

  // ---------------------------------------------------------------
  // stored values and counters
  // ---------------------------------------------------------------
  reg [4:0]  duty_r_reg;
  reg [4:0]  duty_g_reg;
  reg [4:0]  duty_b_reg;
  reg [4:0]  target_reg;
  reg        dir_up_reg;
  reg [4:0]  step_time_reg;
  reg [4:0]  steps_left_reg;
  reg [4:0]  unit_left_reg;
  reg [31:0] unit_cnt_reg;
  reg [31:0] tick_cnt_reg;
  reg [4:0]  slot_reg;
  reg [1:0]  state_reg;
  reg [1:0]  state_next;

  // ---------------------------------------------------------------
  // dimming run state
  // ---------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_RUN  = 2'b10;

  wire       running   = (state_reg == ST_RUN);
  wire       unit_done = (unit_cnt_reg == UNIT_CYC - 1);
  wire       step_done = running && unit_done && (unit_left_reg == 5'h01);
  wire       last_step = step_done && (steps_left_reg == 5'h01);
  wire [4:0] run_dist  = absdiff(led_current_level, target_reg);
  // a zero time or zero distance starts nothing
  wire       run_go    = cmd_run && (val != 5'h00) && (run_dist != 5'h00);
  wire       run_stop  = cmd_shutdown || cmd_current;

  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (run_go)
          state_next = ST_RUN;
      end
      ST_RUN:
      begin
        // a shut down, level or run command in the same cycle as the last step wins over it
        if (run_stop)
          state_next = ST_IDLE;
        else if (cmd_run)
          state_next = run_go ? ST_RUN : ST_IDLE;
        else if (last_step)
          state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always @(posedge clk or negedge rst_l)
  begin
    if (!rst_l)
    begin
      state_reg    <= ST_IDLE;
      dimming_busy <= 1'b0;
    end
    else
    begin
      state_reg    <= state_next;
      dimming_busy <= (state_next == ST_RUN);
    end
  end

  // ---------------------------------------------------------------
  // step interval: step_time units of 8 ms each
  // ---------------------------------------------------------------
  always @(posedge clk or negedge rst_l)
  begin
    if (!rst_l)
    begin
      step_time_reg <= `RGBPWM_RST_VAL;
      unit_left_reg <= `RGBPWM_RST_VAL;
      unit_cnt_reg  <= 32'h0;
    end
    else if (cmd_run)
    begin
      step_time_reg <= val;
      unit_left_reg <= val;
      unit_cnt_reg  <= 32'h0;
    end
    else if (running)
    begin
      unit_cnt_reg <= unit_done ? 32'h0 : unit_cnt_reg + 32'h1;
      if (unit_done)
        unit_left_reg <= (unit_left_reg == 5'h01) ? step_time_reg : unit_left_reg - 5'h01;
    end
  end

  // ---------------------------------------------------------------
  // step position
  // ---------------------------------------------------------------
  // the count is fixed at launch, so no division is ever needed
  always @(posedge clk or negedge rst_l)
  begin
    if (!rst_l)
      steps_left_reg <= `RGBPWM_RST_VAL;
    else if (cmd_run)
      steps_left_reg <= run_dist;
    else if (step_done)
      steps_left_reg <= steps_left_reg - 5'h01;
  end

  // a direct level write or a shut down overrides a step in the same cycle
  always @(posedge clk or negedge rst_l)
  begin
    if (!rst_l)
      led_current_level <= `RGBPWM_RST_VAL;
    else if (cmd_shutdown)
      led_current_level <= `RGBPWM_RST_VAL;
    else if (cmd_current)
      led_current_level <= val;
    else if (step_done)
      led_current_level <= step_toward(led_current_level, dir_up_reg);
  end

  always @(posedge clk or negedge rst_l)
  begin
    if (!rst_l)
      shutdown_out <= 1'b1;
    else if (cmd_shutdown)
      shutdown_out <= 1'b1;
    else if (cmd_current || cmd_run)
      shutdown_out <= 1'b0;
  end

  // ---------------------------------------------------------------
  // end point and direction
  // ---------------------------------------------------------------
  // a change during a run keeps the step count taken at launch, but its direction applies to the remaining steps
  always @(posedge clk or negedge rst_l)
  begin
    if (!rst_l)
    begin
      target_reg <= `RGBPWM_RST_VAL;
      dir_up_reg <= 1'b1;
    end
    else if (cmd_rise)
    begin
      target_reg <= val;
      dir_up_reg <= 1'b1;
    end
    else if (cmd_fall)
    begin
      target_reg <= val;
      dir_up_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // duty codes, writable at any time, even during a run
  // ---------------------------------------------------------------
  always @(posedge clk or negedge rst_l)
  begin
    if (!rst_l)
      duty_r_reg <= `RGBPWM_RST_VAL;
    else if (cmd_red)
      duty_r_reg <= val;
  end

  always @(posedge clk or negedge rst_l)
  begin
    if (!rst_l)
      duty_g_reg <= `RGBPWM_RST_VAL;
    else if (cmd_green)
      duty_g_reg <= val;
  end

  always @(posedge clk or negedge rst_l)
  begin
    if (!rst_l)
      duty_b_reg <= `RGBPWM_RST_VAL;
    else if (cmd_blue)
      duty_b_reg <= val;
  end

  // ---------------------------------------------------------------
  // pwm: 31 slots per period, slot advances at 2.1 kHz * 31
  // ---------------------------------------------------------------
  wire tick = (tick_cnt_reg == TICK_CYC - 1);

  always @(posedge clk or negedge rst_l)
  begin
    if (!rst_l)
      tick_cnt_reg <= 32'h0;
    else
      tick_cnt_reg <= tick ? 32'h0 : tick_cnt_reg + 32'h1;
  end

  // 31 slots, not 32, so the full code leaves no off slot at all
  always @(posedge clk or negedge rst_l)
  begin
    if (!rst_l)
      slot_reg <= 5'h00;
    else if (tick)
      slot_reg <= (slot_reg == `RGBPWM_PWM_LAST) ? 5'h00 : slot_reg + 5'h01;
  end

  // gates only; the current code is never touched here
  // the gates lag the duty write by one clock, which no led can show
  always @(posedge clk or negedge rst_l)
  begin
    if (!rst_l)
    begin
      led_red_on   <= 1'b0;
      led_green_on <= 1'b0;
      led_blue_on  <= 1'b0;
    end
    else
    begin
      led_red_on   <= gate_on(slot_reg, duty_r_reg, shutdown_out);
      led_green_on <= gate_on(slot_reg, duty_g_reg, shutdown_out);
      led_blue_on  <= gate_on(slot_reg, duty_b_reg, shutdown_out);
    end
  end
endmodule // rgbpwm_core

// ### verif/rgbpwm_host.sv
// host model: writes single command bytes, never reads
module rgbpwm_host (
  input  wire        clk,       // clock
  output logic       cmd_valid, // byte strobe
  output logic [7:0] cmd_byte   // command byte
);
  timeunit 1ns;
  timeprecision 1ps;
  initial cmd_valid = 1'b0;
  initial cmd_byte = 8'h00;
  // idle byte is inverted so a stale value never looks valid
  task send(input logic [7:0] b);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_byte <= b;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_byte <= ~b;
  endtask
endmodule // rgbpwm_host

// ### verif/rgbpwm_chk.sv
// port checker for the led pwm core
module rgbpwm_chk (
  input wire       clk,               // clock
  input wire       rst_n,             // reset
  input wire       cmd_valid,         // strobe
  input wire [7:0] cmd_byte,          // byte
  input wire       led_red_on,        // red
  input wire       led_green_on,      // green
  input wire       led_blue_on,       // blue
  input wire [4:0] led_current_level, // level
  input wire       shutdown_out,      // shut down
  input wire       dimming_busy       // run
);
  timeunit 1ns;
  timeprecision 1ps;
  wire [2:0] sel = cmd_byte[7:5];
  wire [4:0] lv = led_current_level;
  logic [4:0] tgt_reg;
  always @(posedge clk or negedge rst_n)
    if (!rst_n) tgt_reg <= 5'h00;
    else if (cmd_valid && (sel == 3'h5 || sel == 3'h6)) tgt_reg <= cmd_byte[4:0];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_sd; shutdown_out |=> !led_red_on && !led_green_on && !led_blue_on; endproperty
  a_sd: assert property (p_sd) else $error("gate on in shut down");
  property p_set; cmd_valid && sel == 3'h1 |=> lv == $past(cmd_byte[4:0]) && !dimming_busy; endproperty
  a_set: assert property (p_set) else $error("level not set");
  property p_off; cmd_valid && sel == 3'h0 |=> lv == 5'h00 && shutdown_out; endproperty
  a_off: assert property (p_off) else $error("shut down ignored");
  property p_step; !cmd_valid |=> $stable(lv) || lv == $past(lv) + 5'h01 || lv == $past(lv) - 5'h01; endproperty
  a_step: assert property (p_step) else $error("level jumped");
  property p_hold; !cmd_valid && !dimming_busy |=> $stable(lv); endproperty
  a_hold: assert property (p_hold) else $error("idle level moved");
  property p_end; $fell(dimming_busy) && !$past(cmd_valid) |-> lv == tgt_reg; endproperty
  a_end: assert property (p_end) else $error("run ended off target");
  property p_go; cmd_valid && sel == 3'h7 && cmd_byte[4:0] != 5'h00 && lv != tgt_reg |=> dimming_busy; endproperty
  a_go: assert property (p_go) else $error("run not started");
  property p_nogo; cmd_valid && sel == 3'h7 && lv == tgt_reg |=> !dimming_busy; endproperty
  a_nogo: assert property (p_nogo) else $error("empty run started");
  property p_full; cmd_valid && cmd_byte == 8'h5f ##1 !shutdown_out |=> led_red_on; endproperty
  a_full: assert property (p_full) else $error("full duty not on");
  property p_zero; cmd_valid && cmd_byte == 8'h60 |-> ##2 !led_green_on; endproperty
  a_zero: assert property (p_zero) else $error("zero duty not off");
endmodule // rgbpwm_chk
bind rgbpwm_core rgbpwm_chk i_rgbpwm_chk (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
  .cmd_byte(cmd_byte), .led_red_on(led_red_on), .led_green_on(led_green_on),
  .led_blue_on(led_blue_on), .led_current_level(led_current_level),
  .shutdown_out(shutdown_out), .dimming_busy(dimming_busy));

// ### verif/tb_rgbpwm_core.sv
// self-checking bench for the led pwm core
module tb_rgbpwm_core;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0;   // clock
  logic       rst_n = 1'b0; // reset
  wire        cv, red, grn, blu, sd, busy;
  wire  [7:0] cb;
  wire  [4:0] lvl;
  int         n_fail = 0;
  int         n_checks = 0;
  int         cnt, on_r, on_g, on_b;
  // rows: command byte, level after, shut down after
  localparam logic [13:0] ROWS [4] = '{{8'h3f, 5'h1f, 1'b0}, {8'h00, 5'h00, 1'b1},
                                       {8'he5, 5'h00, 1'b0}, {8'h25, 5'h05, 1'b0}};
  always #2 clk = ~clk;
  rgbpwm_host i_rgbpwm_host (.clk(clk), .cmd_valid(cv), .cmd_byte(cb));
  rgbpwm_core #(.TICK_CYC(4), .UNIT_CYC(20)) i_rgbpwm_core (.clk(clk), .rst_n(rst_n),
    .cmd_valid(cv), .cmd_byte(cb), .led_red_on(red), .led_green_on(grn), .led_blue_on(blu),
    .led_current_level(lvl), .shutdown_out(sd), .dimming_busy(busy));
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %0t saw %h wanted %h", $time, seen, exp);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // bounded wait for the run to finish
  task run_wait(input int lim);
    for (cnt = 0; busy !== 1'b0 && cnt < lim; cnt++) tick(1);
    if (cnt >= lim)
    begin
      n_fail++;
      tally_and_finish;
    end
  endtask
  initial
  begin
    tick(8);
    rst_n <= 1'b1;
    tick(3);
    foreach (ROWS[i])
    begin
      i_rgbpwm_host.send(ROWS[i][13:6]);
      tick(2);
      check(lvl, ROWS[i][5:1]);
      check(sd, ROWS[i][0]);
    end
    i_rgbpwm_host.send(8'haf);
    i_rgbpwm_host.send(8'he2);
    tick(1);
    check(busy, 1'b1);
    run_wait(1000);
    check(lvl, 5'h0f);
    check(cnt >= 390 && cnt <= 401, 1'b1);
    i_rgbpwm_host.send(8'he3);
    tick(1);
    check(busy, 1'b0);
    i_rgbpwm_host.send(8'hc1);
    i_rgbpwm_host.send(8'he4);
    i_rgbpwm_host.send(8'h4f);
    i_rgbpwm_host.send(8'h60);
    i_rgbpwm_host.send(8'h9f);
    tick(2);
    on_r = 0;
    on_g = 0;
    on_b = 0;
    repeat (124)
    begin
      tick(1);
      on_r += (red === 1'b1);
      on_g += (grn === 1'b1);
      on_b += (blu === 1'b1);
    end
    check(on_r, 60);
    check(on_g, 0);
    check(on_b, 124);
    check(busy, 1'b1);
    i_rgbpwm_host.send(8'h5f);
    tick(3);
    check(red, 1'b1);
    run_wait(2000);
    check(lvl, 5'h01);
    i_rgbpwm_host.send(8'hbf);
    i_rgbpwm_host.send(8'he1);
    tick(3);
    rst_n <= 1'b0;
    tick(2);
    check({busy, sd, lvl}, {1'b0, 1'b1, 5'h00});
    tally_and_finish;
  end
endmodule // tb_rgbpwm_core
